// ==== hdl/ctdio_top.sv ====
// Counter/timer and digital I/O block: eight counters, four interval
// timers, 32 I/O lines and a change-watched port.
// Assumes a plain register port and pins synchronous to sys_clk.
//
// Operation
// - Eight independent 16-bit counters, each with clock in, gate in, clock out.
// - Each counter counts the internal time base or its external clock pin.
// - A counter raises an interrupt request when its count reaches zero.
// - Internal time base has a 30 ns period: the 25 ns target rounded up to three 10 ns clock cycles.
// - Optional internal cascade feeds a counter's output into the next counter's clock.
// - Each gate comes from a software setting or the external gate pin.
// - One-shot on external gate pin edge; event, frequency and rate modes run while gated.
// - Output pulse active edge is selectable falling or rising.
// - Output pulse width, hence duty cycle, is programmable.
// - Four 24-bit interval timers on the internal clock give periodic interrupts.
// - Interval timer period is programmable over a wide range.
// - 32 lines in four 8-line ports, direction set per port.
// - Any change on the watched port's eight lines raises an interrupt.
// - Each watched line has its own enable; disabled lines never set a flag.
// - Counter clock and gate pins are sampled; outside levels must last 25 ns.
// - Watched lines must hold each level 66 ns to be detected.
module ctdio_top
	import ctdio_pkg::*;
(
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic [CT_NUM-1:0] ct_clk_in,
	input wire logic [CT_NUM-1:0] ct_gate_in,
	output logic [CT_NUM-1:0] ct_clk_out,
	input wire logic [DIO_W-1:0] dio_in,
	output logic [DIO_W-1:0] dio_out,
	output logic [DIO_W-1:0] dio_oe,
	output logic irq
);

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	logic [7:0] cc_reg [CT_NUM], cc_next [CT_NUM];
	logic [31:0] cl_reg [CT_NUM], cl_next [CT_NUM];
	logic [24:0] tp_reg [TMR_NUM], tp_next [TMR_NUM];
	logic [TMR_W-1:0] tc_reg [TMR_NUM], tc_next [TMR_NUM];
	logic [DIO_PORTS-1:0] dir_reg, dir_next;
	logic [DIO_W-1:0] dout_reg, dout_next;
	logic [DIO_W-1:0] din_reg;
	logic [7:0] cwen_reg, cwen_next;
	logic [7:0] cwpend_reg, cwpend_next;
	logic [7:0] cwprev_reg;
	logic [7:0] cw_change;
	logic [CT_NUM-1:0] ctpend_reg, ctpend_next;
	logic [TMR_NUM-1:0] tmpend_reg, tmpend_next;
	logic [TMR_NUM-1:0] tm_zero;
	logic [CT_NUM-1:0] reload_reg, reload_next;
	logic [CT_NUM-1:0] clk_s_reg, clk_p_reg, gate_s_reg, gate_p_reg;
	logic [CT_NUM-1:0] out_p_reg;
	logic [CT_NUM-1:0] ct_out, ct_zero, ct_tick, ct_gate, ct_grise, ct_casc;
	logic [CT_W-1:0] ct_count [CT_NUM];
	logic [1:0] tb_reg, tb_next;
	logic tb_tick_reg, tb_tick_next;
	logic [31:0] rdata_reg, rdata_next;
	logic irq_reg, irq_next;
	logic [2:0] ch;
	logic [1:0] tn;

	assign ch = reg_addr[4:2];
	assign tn = reg_addr[3:2];

	// ------------------------------------------------------------------
	// Internal time base
	// ------------------------------------------------------------------
	// Divides the system clock to one tick per time-base period.
	always_comb begin
		tb_next = (tb_reg == TB_LAST) ? 2'h0 : tb_reg + 2'h1;
		tb_tick_next = (tb_reg == TB_LAST);
	end

	// Registers the time base.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			tb_reg <= 2'h0;
			tb_tick_reg <= 1'b0;
		end else begin
			tb_reg <= tb_next;
			tb_tick_reg <= tb_tick_next;
		end
	end

	// ------------------------------------------------------------------
	// Pin sampling
	// ------------------------------------------------------------------
	// Samples clock, gate and watched pins every cycle, faster than 40 MHz.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			clk_s_reg <= '0;
			clk_p_reg <= '0;
			gate_s_reg <= '0;
			gate_p_reg <= '0;
			out_p_reg <= '0;
			din_reg <= '0;
			cwprev_reg <= '0;
		end else begin
			clk_s_reg <= ct_clk_in;
			clk_p_reg <= clk_s_reg;
			gate_s_reg <= ct_gate_in;
			gate_p_reg <= gate_s_reg;
			out_p_reg <= ct_out;
			din_reg <= dio_in;
			cwprev_reg <= din_reg[DIO_W-1:CW_LO];
		end
	end

	// ------------------------------------------------------------------
	// Counter channels
	// ------------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < CT_NUM; g++) begin : g_ct
			// Active edge of the previous channel's output drives the cascade.
			if (g == 0) begin : g_first
				assign ct_casc[g] = 1'b0;
			end else begin : g_next
				assign ct_casc[g] = (ct_out[g-1] != out_p_reg[g-1])
					&& (ct_out[g-1] == cc_reg[g-1][CC_POL]);
			end
			// Chooses the tick source and the gate source.
			always_comb begin
				if (cc_reg[g][CC_CASCADE]) begin
					ct_tick[g] = ct_casc[g];
				end else if (cc_reg[g][CC_CLK_EXT]) begin
					ct_tick[g] = clk_s_reg[g] && !clk_p_reg[g];
				end else begin
					ct_tick[g] = tb_tick_reg;
				end
				ct_gate[g] = cc_reg[g][CC_GATE_EXT] ? gate_s_reg[g] : cc_reg[g][CC_SW_GATE];
				ct_grise[g] = cc_reg[g][CC_GATE_EXT] && gate_s_reg[g] && !gate_p_reg[g];
			end
			ctdio_counter u_ct (
				.sys_clk(sys_clk),
				.arst_n(arst_n),
				.enable(cc_reg[g][CC_EN]),
				.mode(cc_reg[g][CC_MODE_LO+1:CC_MODE_LO]),
				.polarity(cc_reg[g][CC_POL]),
				.start_val(cl_reg[g][15:0]),
				.width(cl_reg[g][31:16]),
				.reload(reload_reg[g]),
				.tick(ct_tick[g]),
				.gate(ct_gate[g]),
				.gate_rise(ct_grise[g]),
				.count_q(ct_count[g]),
				.out_q(ct_out[g]),
				.zero_q(ct_zero[g])
			);
		end
		// Interval timers count the time base and reload at zero.
		for (g = 0; g < TMR_NUM; g++) begin : g_tm
			always_comb begin
				tm_zero[g] = 1'b0;
				tc_next[g] = tc_reg[g];
				if (!tp_reg[g][TP_EN]) begin
					tc_next[g] = tp_reg[g][TMR_W-1:0];
				end else if (tb_tick_reg) begin
					if (tc_reg[g] == 24'h00_0000) begin
						tc_next[g] = tp_reg[g][TMR_W-1:0];
						tm_zero[g] = 1'b1;
					end else begin
						tc_next[g] = tc_reg[g] - 24'h00_0001;
					end
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------------
	// Register file and event flags
	// ------------------------------------------------------------------
	// Writes, reads and sticky flags; a new event wins over its clear.
	always_comb begin
		cc_next = cc_reg;
		cl_next = cl_reg;
		tp_next = tp_reg;
		dir_next = dir_reg;
		dout_next = dout_reg;
		cwen_next = cwen_reg;
		reload_next = '0;
		cw_change = (din_reg[DIO_W-1:CW_LO] ^ cwprev_reg) & cwen_reg;
		cwpend_next = cwpend_reg;
		ctpend_next = ctpend_reg;
		tmpend_next = tmpend_reg;
		rdata_next = 32'h0000_0000;
		if (reg_wr) begin
			if (reg_addr[7:5] == OFS_CT_CTRL[7:5] && reg_addr[1:0] == 2'h0) begin
				cc_next[ch] = reg_wdata[7:0];
			end else if (reg_addr[7:5] == OFS_CT_LOAD[7:5] && reg_addr[1:0] == 2'h0) begin
				cl_next[ch] = reg_wdata;
				reload_next[ch] = 1'b1;
			end else if (reg_addr[7:4] == OFS_TMR_PER[7:4] && reg_addr[1:0] == 2'h0) begin
				tp_next[tn] = reg_wdata[24:0];
			end else begin
				case (reg_addr)
					OFS_DIO_DIR: dir_next = reg_wdata[DIO_PORTS-1:0];
					OFS_DIO_OUT: dout_next = reg_wdata;
					OFS_CW_EN: cwen_next = reg_wdata[7:0];
					OFS_CW_PEND: cwpend_next = cwpend_reg & ~reg_wdata[7:0];
					OFS_EV_PEND: begin
						ctpend_next = ctpend_reg & ~reg_wdata[7:0];
						tmpend_next = tmpend_reg & ~reg_wdata[11:8];
					end
					default: begin
					end
				endcase
			end
		end
		cwpend_next = cwpend_next | cw_change;
		ctpend_next = ctpend_next | ct_zero;
		tmpend_next = tmpend_next | tm_zero;
		if (reg_rd) begin
			if (reg_addr[7:5] == OFS_CT_CTRL[7:5] && reg_addr[1:0] == 2'h0) begin
				rdata_next = {24'h00_0000, cc_reg[ch]};
			end else if (reg_addr[7:5] == OFS_CT_LOAD[7:5] && reg_addr[1:0] == 2'h0) begin
				rdata_next = cl_reg[ch];
			end else if (reg_addr[7:5] == OFS_CT_COUNT[7:5] && reg_addr[1:0] == 2'h0) begin
				rdata_next = {16'h0000, ct_count[ch]};
			end else if (reg_addr[7:4] == OFS_TMR_PER[7:4] && reg_addr[1:0] == 2'h0) begin
				rdata_next = {7'h00, tp_reg[tn]};
			end else begin
				case (reg_addr)
					OFS_DIO_DIR: rdata_next = {28'h000_0000, dir_reg};
					OFS_DIO_OUT: rdata_next = dout_reg;
					OFS_DIO_IN: rdata_next = din_reg;
					OFS_CW_EN: rdata_next = {24'h00_0000, cwen_reg};
					OFS_CW_PEND: rdata_next = {24'h00_0000, cwpend_reg};
					OFS_EV_PEND: rdata_next = {20'h0_0000, tmpend_reg, ctpend_reg};
					default: rdata_next = 32'h0000_0000;
				endcase
			end
		end
		irq_next = (|cwpend_next) || (|ctpend_next) || (|tmpend_next);
	end

	// Registers the register file, flags and pin drivers.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < CT_NUM; i++) begin
				cc_reg[i] <= CC_RESET;
				cl_reg[i] <= CT_LOAD_RESET;
			end
			for (int i = 0; i < TMR_NUM; i++) begin
				tp_reg[i] <= TP_RESET;
				tc_reg[i] <= 24'h00_0000;
			end
			dir_reg <= '0;
			dout_reg <= '0;
			cwen_reg <= '0;
			cwpend_reg <= '0;
			ctpend_reg <= '0;
			tmpend_reg <= '0;
			reload_reg <= '0;
			rdata_reg <= 32'h0000_0000;
			irq_reg <= 1'b0;
			dio_out <= '0;
			dio_oe <= '0;
		end else begin
			cc_reg <= cc_next;
			cl_reg <= cl_next;
			tp_reg <= tp_next;
			tc_reg <= tc_next;
			dir_reg <= dir_next;
			dout_reg <= dout_next;
			cwen_reg <= cwen_next;
			cwpend_reg <= cwpend_next;
			ctpend_reg <= ctpend_next;
			tmpend_reg <= tmpend_next;
			reload_reg <= reload_next;
			rdata_reg <= rdata_next;
			irq_reg <= irq_next;
			dio_out <= dout_next;
			for (int i = 0; i < DIO_W; i++) begin
				dio_oe[i] <= dir_next[i/8];
			end
		end
	end

	assign reg_rdata = rdata_reg;
	assign ct_clk_out = ct_out;
	assign irq = irq_reg;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	tb_spacing_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		tb_tick_reg |=> !tb_tick_reg ##1 !tb_tick_reg ##1 tb_tick_reg)
		else $error("time base tick spacing wrong");
	cw_latch_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		|cw_change |=> |cwpend_reg ##1 irq_reg)
		else $error("watched change not latched");
	cw_mask_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(!reg_wr && ((cwpend_reg ^ cwpend_next) & ~cwen_reg) != 8'h00) |-> 1'b0)
		else $error("disabled line set a flag");
	tm_period_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		tm_zero[0] |=> tmpend_reg[0] && tc_reg[0] == $past(tp_reg[0][TMR_W-1:0]))
		else $error("interval timer did not reload and flag");
	ct_flag_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		ct_zero[0] |=> ctpend_reg[0] ##1 irq_reg)
		else $error("counter zero not flagged");
	dir_drive_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(reg_wr && reg_addr == OFS_DIO_DIR) |=> dio_oe[31:24] == {8{$past(reg_wdata[3])}}
			&& dio_oe[7:0] == {8{$past(reg_wdata[0])}})
		else $error("port direction not applied");
	ext_gate_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		cc_reg[2][CC_GATE_EXT] |-> ct_gate[2] == $past(ct_gate_in[2]))
		else $error("external gate not used");

endmodule : ctdio_top

// ==== hdl/ctdio_pkg.sv ====
// Package for the counter/timer and digital I/O block.
// Assumes one 100 MHz clock; all constants of the block live here.
package ctdio_pkg;

	// ------------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------------
	localparam int unsigned CT_NUM = 8;
	localparam int unsigned CT_W = 16;
	localparam int unsigned TMR_NUM = 4;
	localparam int unsigned TMR_W = 24;
	localparam int unsigned DIO_PORTS = 4;
	localparam int unsigned DIO_W = 32;
	localparam int unsigned CW_LO = 24;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned TB_PERIOD_NS = 25;
	// A least time rounds up to whole cycles.
	localparam int unsigned TB_CYC = (TB_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [1:0] TB_LAST = 2'(TB_CYC - 1);

	// ------------------------------------------------------------------
	// Register offsets (byte addresses)
	// ------------------------------------------------------------------
	localparam logic [7:0] OFS_CT_CTRL = 8'h00;
	localparam logic [7:0] OFS_CT_LOAD = 8'h20;
	localparam logic [7:0] OFS_CT_COUNT = 8'h40;
	localparam logic [7:0] OFS_TMR_PER = 8'h60;
	localparam logic [7:0] OFS_DIO_DIR = 8'h70;
	localparam logic [7:0] OFS_DIO_OUT = 8'h74;
	localparam logic [7:0] OFS_DIO_IN = 8'h78;
	localparam logic [7:0] OFS_CW_EN = 8'h7C;
	localparam logic [7:0] OFS_CW_PEND = 8'h80;
	localparam logic [7:0] OFS_EV_PEND = 8'h84;

	// ------------------------------------------------------------------
	// Counter control fields
	// ------------------------------------------------------------------
	localparam int unsigned CC_EN = 0;
	localparam int unsigned CC_CLK_EXT = 1;
	localparam int unsigned CC_GATE_EXT = 2;
	localparam int unsigned CC_SW_GATE = 3;
	localparam int unsigned CC_MODE_LO = 4;
	localparam int unsigned CC_POL = 6;
	localparam int unsigned CC_CASCADE = 7;
	localparam int unsigned TP_EN = 24;
	localparam logic [7:0] CC_RESET = 8'h00;
	localparam logic [31:0] CT_LOAD_RESET = 32'h0000_0000;
	localparam logic [24:0] TP_RESET = 25'h000_0000;

	// Counting modes.
	typedef enum logic [1:0] {
		CTDIO_MODE_EVENT = 2'h0,
		CTDIO_MODE_RATE = 2'h1,
		CTDIO_MODE_ONESHOT = 2'h2,
		CTDIO_MODE_FREQ = 2'h3
	} ctdio_mode_e;

	// Counter channel states.
	typedef enum logic [2:0] {
		CTDIO_ST_IDLE = 3'h1,
		CTDIO_ST_RUN = 3'h2,
		CTDIO_ST_HOLD = 3'h4
	} ctdio_state_e;

endpackage : ctdio_pkg

// ==== hdl/ctdio_counter.sv ====
// One 16-bit counter/timer channel with gate, modes and a shaped output.
// Assumes the tick and gate arrive already chosen and registered by the parent.
module ctdio_counter
	import ctdio_pkg::*;
(
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic enable,
	input wire logic [1:0] mode,
	input wire logic polarity,
	input wire logic [CT_W-1:0] start_val,
	input wire logic [CT_W-1:0] width,
	input wire logic reload,
	input wire logic tick,
	input wire logic gate,
	input wire logic gate_rise,
	output logic [CT_W-1:0] count_q,
	output logic out_q,
	output logic zero_q
);

	ctdio_state_e st_reg, st_next;
	logic [CT_W-1:0] cnt_reg, cnt_next;
	logic out_reg, out_next;
	logic zero_reg, zero_next;
	logic active;

	// ------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------
	// Counts down per tick while gated, up in frequency mode; one-shot waits for a gate edge.
	always_comb begin
		st_next = st_reg;
		cnt_next = cnt_reg;
		zero_next = 1'b0;
		if (!enable || reload) begin
			cnt_next = start_val;
			st_next = CTDIO_ST_IDLE;
		end else begin
			case (st_reg)
				CTDIO_ST_IDLE: begin
					if (mode == CTDIO_MODE_ONESHOT) begin
						if (gate_rise) begin
							st_next = CTDIO_ST_RUN;
							cnt_next = start_val;
						end
					end else if (gate) begin
						st_next = CTDIO_ST_RUN;
					end
				end
				CTDIO_ST_RUN: begin
					if (mode != CTDIO_MODE_ONESHOT && !gate) begin
						st_next = CTDIO_ST_IDLE; // Gate low pauses, count is kept.
					end else if (tick) begin
						if (mode == CTDIO_MODE_FREQ) begin
							cnt_next = cnt_reg + 16'h0001;
						end else if (cnt_reg <= 16'h0001) begin
							zero_next = 1'b1;
							if (mode == CTDIO_MODE_RATE) begin
								cnt_next = start_val;
							end else begin
								cnt_next = 16'h0000;
								st_next = CTDIO_ST_HOLD;
							end
						end else begin
							cnt_next = cnt_reg - 16'h0001;
						end
					end
				end
				CTDIO_ST_HOLD: begin
					if (mode == CTDIO_MODE_ONESHOT && gate_rise) begin
						st_next = CTDIO_ST_RUN; // A new gate edge retriggers.
						cnt_next = start_val;
					end
				end
				default: begin
					st_next = CTDIO_ST_IDLE;
				end
			endcase
		end
		// Active while the remaining count is within the programmed width.
		active = (st_next == CTDIO_ST_RUN) && (mode != CTDIO_MODE_FREQ) && (cnt_next <= width);
		out_next = polarity ? active : !active;
	end

	// Registers the channel state.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg <= CTDIO_ST_IDLE;
			cnt_reg <= 16'h0000;
			out_reg <= 1'b0;
			zero_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			cnt_reg <= cnt_next;
			out_reg <= out_next;
			zero_reg <= zero_next;
		end
	end

	assign count_q = cnt_reg;
	assign out_q = out_reg;
	assign zero_q = zero_reg;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	zero_cause_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		zero_reg |-> $past(tick) && $past(st_reg) == CTDIO_ST_RUN && $past(enable))
		else $error("zero pulse without a running tick");
	rate_reload_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(st_reg == CTDIO_ST_RUN && mode == CTDIO_MODE_RATE && enable && !reload && gate
			&& tick && cnt_reg == 16'h0001) |=> cnt_reg == $past(start_val) && zero_reg)
		else $error("rate mode did not reload at zero");
	// The output keeps its reset level for the first edge after release.
	idle_level_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		($past(arst_n) && st_reg != CTDIO_ST_RUN && $stable(polarity)) |-> out_reg == !polarity)
		else $error("inactive output level wrong");
	gate_pause_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(enable && !reload && mode == CTDIO_MODE_EVENT && !gate) |=> $stable(cnt_reg))
		else $error("count moved while gate inactive");

endmodule : ctdio_counter

// ==== bench/ctdio_host.sv ====
// Host model that masters the register port of the block.
// Assumes sys_clk comes from the bench and one access runs at a time.
module ctdio_host (
	input wire logic sys_clk,
	output logic [7:0] reg_addr,
	output logic [31:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [31:0] reg_rdata
);
	timeunit 1ns;
	timeprecision 1ps;

	// Bus is idle from time zero.
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 32'h0000_0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	// One write: strobe, address and data stand for one edge, then data are scrambled.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
	endtask : wr

	// One read: the data are taken at the edge that ends the cycle after the strobe.
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(posedge sys_clk);
		d = reg_rdata;
	endtask : rd
endmodule : ctdio_host

// ==== bench/tb_top.sv ====
// Self-checking bench for the counter/timer and digital I/O block.
// Assumes the host model in ctdio_host and a 100 MHz sys_clk.
`define CHK(a, b) check_val(32'(a), 32'(b))
module tb_top
	import ctdio_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk, arst_n, reg_wr, reg_rd, irq, irq_q;
	logic [7:0] reg_addr, ct_clk_in, ct_gate_in, ct_clk_out;
	logic [31:0] reg_wdata, reg_rdata, dio_in, dio_out, dio_oe, rv;
	int err_total, check_count, cyc, rise_cyc, rise_cnt, hi, lo, c0, c1;

	// ----------------------------------------------------------------
	// Instances
	// ----------------------------------------------------------------
	ctdio_top dut (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.ct_clk_in(ct_clk_in), .ct_gate_in(ct_gate_in), .ct_clk_out(ct_clk_out),
		.dio_in(dio_in), .dio_out(dio_out), .dio_oe(dio_oe), .irq(irq));
	ctdio_host u_host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

	// Clock of 10 ns period.
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// Cycle count cuts a hang short; irq rises are time-stamped.
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			end_sim();
		end
	end
	always @(negedge sys_clk) begin
		irq_q <= irq;
		if (irq === 1'b1 && irq_q === 1'b0) begin
			rise_cyc <= cyc;
			rise_cnt <= rise_cnt + 1;
		end
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask : check_val

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		u_host.rd(a, rv);
		`CHK(rv, exp);
	endtask : rd_chk

	// Pulses last 3 cycles high and 4 low, above the least sampled width.
	task automatic pulse(input int ch, input int n);
		repeat (n) begin
			@(posedge sys_clk);
			ct_clk_in[ch] <= 1'b1;
			repeat (3) @(posedge sys_clk);
			ct_clk_in[ch] <= 1'b0;
			repeat (3) @(posedge sys_clk);
		end
	endtask : pulse

	task automatic run_len(input int ch, input logic lvl, output int n);
		n = 0;
		while (ct_clk_out[ch] === lvl && n < 1000) begin
			@(negedge sys_clk);
			n++;
		end
	endtask : run_len

	task automatic wait_rise(output int c);
		int r;
		r = rise_cnt;
		while (rise_cnt == r) @(negedge sys_clk);
		c = rise_cyc;
	endtask : wait_rise

	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : end_sim

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		repeat (2) @(negedge sys_clk);
		`CHK(ct_clk_out, 8'hFF);
		`CHK(dio_oe, 0);
		`CHK(irq, 0);
		rd_chk(OFS_CT_CTRL + 8'h1C, 32'(CC_RESET));
		rd_chk(OFS_CT_LOAD + 8'h1C, CT_LOAD_RESET);
		rd_chk(OFS_TMR_PER + 8'h0C, 32'(TP_RESET));
		u_host.wr(8'hC0, 32'hFFFF_FFFF);
		rd_chk(8'hC0, 32'h0000_0000);
	endtask : t_reset

	task automatic t_dio();
		u_host.wr(OFS_DIO_DIR, 32'h0000_0005);
		u_host.wr(OFS_DIO_OUT, 32'hA5C3_9617);
		@(negedge sys_clk);
		`CHK(dio_oe, 32'h00FF_00FF);
		`CHK(dio_out, 32'hA5C3_9617);
		u_host.wr(OFS_DIO_DIR, 32'h0000_000A);
		dio_in <= 32'h0034_0056;
		@(negedge sys_clk);
		`CHK(dio_oe, 32'hFF00_FF00);
		rd_chk(OFS_DIO_IN, 32'h0034_0056);
	endtask : t_dio

	// Watched lines 0 and 7 enabled; each level is held at least 7 cycles.
	task automatic t_watch();
		u_host.wr(OFS_CW_EN, 32'h0000_0081);
		dio_in <= dio_in ^ 32'h0200_0001;
		repeat (10) @(posedge sys_clk);
		rd_chk(OFS_CW_PEND, 32'h0000_0000);
		`CHK(irq, 0);
		dio_in <= dio_in ^ 32'h8100_0000;
		repeat (7) @(posedge sys_clk);
		rd_chk(OFS_CW_PEND, 32'h0000_0081);
		`CHK(irq, 1);
		u_host.wr(OFS_CW_PEND, 32'h0000_0001);
		rd_chk(OFS_CW_PEND, 32'h0000_0080);
		u_host.wr(OFS_CW_PEND, 32'h0000_0080);
		rd_chk(OFS_CW_PEND, 32'h0000_0000);
		`CHK(irq, 0);
		dio_in <= dio_in ^ 32'h0100_0000;
		repeat (7) @(posedge sys_clk);
		rd_chk(OFS_CW_PEND, 32'h0000_0001);
		u_host.wr(OFS_CW_PEND, 32'h0000_0001);
	endtask : t_watch

	// Channel 1 counts external clock edges down from 3.
	task automatic t_event();
		u_host.wr(OFS_CT_LOAD + 8'h04, 32'h0000_0003);
		u_host.wr(OFS_CT_CTRL + 8'h04, 32'h0000_000B);
		pulse(1, 2);
		rd_chk(OFS_CT_COUNT + 8'h04, 32'h0000_0001);
		rd_chk(OFS_EV_PEND, 32'h0000_0000);
		pulse(1, 1);
		rd_chk(OFS_CT_COUNT + 8'h04, 32'h0000_0000);
		rd_chk(OFS_EV_PEND, 32'h0000_0002);
		`CHK(irq, 1);
		u_host.wr(OFS_EV_PEND, 32'h0000_0FFF);
		rd_chk(OFS_EV_PEND, 32'h0000_0000);
	endtask : t_event

	// External gate pauses counting even with the software gate set.
	task automatic t_gate();
		u_host.wr(OFS_CT_LOAD + 8'h08, 32'h0000_0005);
		u_host.wr(OFS_CT_CTRL + 8'h08, 32'h0000_000F);
		pulse(2, 2);
		rd_chk(OFS_CT_COUNT + 8'h08, 32'h0000_0005);
		ct_gate_in[2] <= 1'b1;
		pulse(2, 2);
		rd_chk(OFS_CT_COUNT + 8'h08, 32'h0000_0003);
	endtask : t_gate

	// Frequency mode counts up; one-shot fires on a gate edge.
	task automatic t_modes();
		u_host.wr(OFS_CT_LOAD + 8'h14, 32'h0000_0000);
		u_host.wr(OFS_CT_CTRL + 8'h14, 32'h0000_003B);
		pulse(5, 3);
		rd_chk(OFS_CT_COUNT + 8'h14, 32'h0000_0003);
		u_host.wr(OFS_CT_LOAD + 8'h18, 32'h0004_0004);
		u_host.wr(OFS_CT_CTRL + 8'h18, 32'h0000_0065);
		repeat (4) @(negedge sys_clk);
		`CHK(ct_clk_out[6], 0);
		@(posedge sys_clk);
		ct_gate_in[6] <= 1'b1;
		repeat (6) @(negedge sys_clk);
		`CHK(ct_clk_out[6], 1);
		repeat (20) @(negedge sys_clk);
		`CHK(ct_clk_out[6], 0);
		rd_chk(OFS_EV_PEND, 32'h0000_0040);
		u_host.wr(OFS_EV_PEND, 32'h0000_0FFF);
	endtask : t_modes

	// Rate mode on the time base: start 4 gives a 12-cycle period.
	task automatic t_rate();
		int n;
		for (int p = 0; p < 2; p++) begin
			for (int w = 1; w < 3; w++) begin
				u_host.wr(OFS_CT_LOAD, {16'(w), 16'h0004});
				u_host.wr(OFS_CT_CTRL, 32'h0000_0019 | 32'(p << 6));
				@(negedge sys_clk);
				run_len(0, p[0], n);
				run_len(0, !p[0], n);
				run_len(0, p[0], hi);
				run_len(0, !p[0], lo);
				`CHK(hi, 3 * w);
				`CHK(hi + lo, 12);
			end
		end
		u_host.wr(OFS_CT_CTRL, 32'h0000_0000);
	endtask : t_rate

	// Channel 4 counts the active edges of channel 3.
	task automatic t_cascade();
		int n;
		u_host.wr(OFS_CT_LOAD + 8'h0C, 32'h0001_0064);
		u_host.wr(OFS_CT_LOAD + 8'h10, 32'h0000_0003);
		u_host.wr(OFS_CT_CTRL + 8'h10, 32'h0000_0089);
		u_host.wr(OFS_CT_CTRL + 8'h0C, 32'h0000_0059);
		@(negedge sys_clk);
		run_len(3, 1'b1, n);
		run_len(3, 1'b0, n);
		repeat (3) @(posedge sys_clk);
		rd_chk(OFS_CT_COUNT + 8'h10, 32'h0000_0002);
		run_len(3, 1'b1, n);
		run_len(3, 1'b0, n);
		repeat (3) @(posedge sys_clk);
		rd_chk(OFS_CT_COUNT + 8'h10, 32'h0000_0001);
		u_host.wr(OFS_CT_CTRL + 8'h0C, 32'h0000_0000);
		u_host.wr(OFS_EV_PEND, 32'h0000_0FFF);
	endtask : t_cascade

	// Each interval timer with period p raises a flag every 3*(p+1) cycles.
	task automatic t_timer();
		for (int t = 0; t < 4; t++) begin
			u_host.wr(OFS_EV_PEND, 32'h0000_0FFF);
			u_host.wr(OFS_TMR_PER + 8'(4 * t), 32'h0100_0000 | 32'(t + 1));
			wait_rise(c0);
			u_host.wr(OFS_EV_PEND, 32'h0000_0F00);
			wait_rise(c1);
			`CHK(c1 - c0, 3 * (t + 2));
			u_host.wr(OFS_TMR_PER + 8'(4 * t), 32'h0000_0000);
			u_host.wr(OFS_EV_PEND, 32'h0000_0F00);
		end
	endtask : t_timer

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		arst_n = 1'b0;
		ct_clk_in = 8'h00;
		ct_gate_in = 8'h00;
		dio_in = 32'h0000_0000;
		repeat (2) @(posedge sys_clk);
		arst_n <= 1'b1;
		t_reset();
		t_dio();
		t_watch();
		t_event();
		t_gate();
		t_modes();
		t_rate();
		t_cascade();
		t_timer();
		end_sim();
	end
endmodule : tb_top
